/* src/dcdc_supply_voltage_monitor_pkg.sv */
// Purpose: shared constants for the converter and supply monitor register bank
// Assumes: word-addressed byte offsets on a plain register port
// Notes: chosen offsets for interrupt registers sit above the monitor block, transfer registers below it
package dcdc_supply_voltage_monitor_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LP_VOLT = 8'h64;
  localparam logic [7:0] OFS_LP_CTRL = 8'h6c;
  localparam logic [7:0] OFS_LN_FREQ = 8'h70;
  localparam logic [7:0] OFS_SYNC_STAT = 8'h78;
  localparam logic [7:0] OFS_CONV_CTRL = 8'h7c;
  localparam logic [7:0] OFS_MON_MAIN = 8'h90;
  localparam logic [7:0] OFS_MON_ALT = 8'h94;
  localparam logic [7:0] OFS_IRQ_STAT = 8'ha0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'ha4;
  // ----------------------------------------------------------------
  // writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_LP_VOLT = 32'h0000_01ff;
  localparam logic [31:0] RST_LP_VOLT = 32'h0000_0168;
  localparam logic [31:0] MASK_LP_CTRL = 32'h0700_f000;
  localparam logic [31:0] RST_LP_CTRL = 32'h0300_0000;
  localparam logic [31:0] MASK_LN_FREQ = 32'h1f00_0007;
  localparam logic [31:0] RST_LN_FREQ = 32'h1000_0000;
  localparam logic [31:0] MASK_CONV_CTRL = 32'h0000_ffff;
  localparam logic [31:0] RST_CONV_CTRL = 32'h0000_0000;
  localparam logic [31:0] MASK_MON_MAIN = 32'h00ff_ff0d;
  localparam logic [31:0] MASK_MON_ALT = 32'h0000_ff0d;
  localparam logic [31:0] RST_MON = 32'h0000_0000;
  localparam logic [3:0] MASK_IRQ = 4'hf;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_LP_ATTEN = 0;
  localparam int POS_LP_REF = 1;
  localparam int POS_HYST = 12;
  localparam int POS_DUTY = 24;
  localparam int POS_BLANK = 25;
  localparam int POS_TRIM = 24;
  localparam int POS_BAND = 0;
  localparam int POS_BUSY = 0;
  localparam int POS_EN = 0;
  localparam int POS_RISE_WU = 2;
  localparam int POS_FALL_WU = 3;
  localparam int POS_RISE_FINE = 16;
  localparam int POS_RISE_COARSE = 20;
  localparam int POS_FALL_FINE = 8;
  localparam int POS_FALL_COARSE = 12;
  localparam logic RST_LN_ATTEN = 1'b0;
  // transfer into the oscillator domain, in system clocks
  localparam int XFER_CYCLES = 8;
endpackage

/* src/dcdc_supply_voltage_monitor_config_regs.sv */
// Purpose: converter and supply monitor configuration and status registers
// Assumes: one 200 MHz clock; supply comparator outputs arrive asynchronously
// Notes: converter fields use the power-on reset, monitor fields the extended reset
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - low-noise attenuation: 0 is third, 1 sixth
// - bias duty cycle enable bit 24, reset one
// - sleep hysteresis bits 15:12, reset zero
// - oscillator band bits 2:0, reset zero
// - busy flag high during domain transfer
// - rising thresholds at 23:20 and 19:16
// - falling thresholds at 15:12 and 11:8
// - falling wakeup bit 3 wakes hibernate
// - rising wakeup bit 2 wakes hibernate
// - alternate channel single threshold pair
// - monitor fields cleared by extended reset only
module dcdc_supply_voltage_monitor_config_regs #(
  parameter int XFER_LEN = dcdc_supply_voltage_monitor_pkg::XFER_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_rst_n_i,
  input wire logic [dcdc_supply_voltage_monitor_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dcdc_supply_voltage_monitor_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic hibernate_state_i,
  input wire logic main_supply_above_i,
  input wire logic alt_supply_above_i,
  output logic [dcdc_supply_voltage_monitor_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  output logic wakeup_o,
  output logic lownoise_fb_atten_o,
  output logic [7:0] lowpower_reference_sel_o,
  output logic lowpower_fb_atten_o,
  output logic [1:0] lowpower_blanking_o,
  output logic bias_duty_cycle_enable_o,
  output logic [3:0] sleep_comparator_hysteresis_o,
  output logic [4:0] osc_trim_o,
  output logic [2:0] osc_band_select_o,
  output logic [15:0] converter_control_o,
  output logic main_monitor_en_o,
  output logic alt_monitor_en_o
);
  import dcdc_supply_voltage_monitor_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic wr_lp_volt = wr_i && hit(addr_i, OFS_LP_VOLT);
  wire logic wr_lp_ctrl = wr_i && hit(addr_i, OFS_LP_CTRL);
  wire logic wr_ln_freq = wr_i && hit(addr_i, OFS_LN_FREQ);
  wire logic wr_conv = wr_i && hit(addr_i, OFS_CONV_CTRL);
  wire logic wr_mon_main = wr_i && hit(addr_i, OFS_MON_MAIN);
  wire logic wr_mon_alt = wr_i && hit(addr_i, OFS_MON_ALT);
  wire logic wr_mask = wr_i && hit(addr_i, OFS_IRQ_MASK);
  wire logic rd_stat = rd_i && hit(addr_i, OFS_IRQ_STAT);

  // ----------------------------------------------------------------
  // converter registers on the power-on reset
  // ----------------------------------------------------------------
  logic [31:0] lp_volt_q;
  logic [31:0] lp_ctrl_q;
  logic [31:0] ln_freq_q;
  logic [31:0] conv_q;
  logic ln_atten_q;
  logic busy_q;
  logic [7:0] xfer_cnt_q;
  wire logic busy_done = busy_q && (xfer_cnt_q == 8'(XFER_LEN - 1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lp_volt_q <= RST_LP_VOLT;
      lp_ctrl_q <= RST_LP_CTRL;
      ln_freq_q <= RST_LN_FREQ;
      ln_atten_q <= RST_LN_ATTEN;
      conv_q <= RST_CONV_CTRL;
    end else begin
      if (wr_lp_volt) begin
        lp_volt_q <= wdata_i & MASK_LP_VOLT;
      end
      if (wr_lp_ctrl) begin
        lp_ctrl_q <= wdata_i & MASK_LP_CTRL;
      end
      if (wr_ln_freq) begin
        ln_freq_q <= wdata_i & MASK_LN_FREQ;
      end
      if (wr_conv && !busy_q) begin
        conv_q <= wdata_i & MASK_CONV_CTRL;
        ln_atten_q <= wdata_i[1];
      end
    end
  end

  // transfer busy: held while a control word crosses to the oscillator domain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      xfer_cnt_q <= 8'h00;
    end else if (wr_conv && !busy_q) begin
      busy_q <= 1'b1;
      xfer_cnt_q <= 8'h00;
    end else if (busy_done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      xfer_cnt_q <= xfer_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // monitor registers on the extended reset
  // ----------------------------------------------------------------
  logic [31:0] mon_main_q;
  logic [31:0] mon_alt_q;

  always_ff @(posedge clk_i or negedge ext_rst_n_i) begin
    if (!ext_rst_n_i) begin
      mon_main_q <= RST_MON;
      mon_alt_q <= RST_MON;
    end else begin
      if (wr_mon_main) begin
        mon_main_q <= wdata_i & MASK_MON_MAIN;
      end
      if (wr_mon_alt) begin
        mon_alt_q <= wdata_i & MASK_MON_ALT;
      end
    end
  end

  // ----------------------------------------------------------------
  // supply crossings and wakeup
  // ----------------------------------------------------------------
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] prev_q;
  // edges are ignored until the sync chain and history hold real pin levels
  logic [2:0] prime_q;
  wire logic primed = prime_q[2];
  wire logic [1:0] chan_en = {mon_alt_q[POS_EN], mon_main_q[POS_EN]};
  wire logic [1:0] rise_wu = {mon_alt_q[POS_RISE_WU], mon_main_q[POS_RISE_WU]};
  wire logic [1:0] fall_wu = {mon_alt_q[POS_FALL_WU], mon_main_q[POS_FALL_WU]};
  wire logic [1:0] rise_ev = sync2_q & ~prev_q & chan_en & {2{primed}};
  wire logic [1:0] fall_ev = ~sync2_q & prev_q & chan_en & {2{primed}};
  wire logic wake_hit = hibernate_state_i &&
    (|(rise_ev & rise_wu) || |(fall_ev & fall_wu));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q <= 2'h0;
      prime_q <= 3'h0;
    end else begin
      sync1_q <= {alt_supply_above_i, main_supply_above_i};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // interrupts: [0] main rise, [1] main fall, [2] alt rise, [3] alt fall
  // ----------------------------------------------------------------
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  wire logic [3:0] irq_set = {fall_ev[1], rise_ev[1], fall_ev[0], rise_ev[0]};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end else begin
      irq_stat_q <= (rd_stat ? 4'h0 : irq_stat_q) | irq_set;
      if (wr_mask) begin
        irq_mask_q <= wdata_i[3:0] & MASK_IRQ;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux, reserved bits zero
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    case (addr_i)
      OFS_LP_VOLT: rmux = lp_volt_q;
      OFS_LP_CTRL: rmux = lp_ctrl_q;
      OFS_LN_FREQ: rmux = ln_freq_q;
      OFS_SYNC_STAT: rmux = {31'h0, busy_q};
      OFS_CONV_CTRL: rmux = conv_q;
      OFS_MON_MAIN: rmux = mon_main_q;
      OFS_MON_ALT: rmux = mon_alt_q;
      OFS_IRQ_STAT: rmux = {28'h0, irq_stat_q};
      OFS_IRQ_MASK: rmux = {28'h0, irq_mask_q};
      default: rmux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0;
      irq_o <= 1'b0;
      wakeup_o <= 1'b0;
      lownoise_fb_atten_o <= 1'b0;
      lowpower_reference_sel_o <= 8'h0;
      lowpower_fb_atten_o <= 1'b0;
      lowpower_blanking_o <= 2'h0;
      bias_duty_cycle_enable_o <= 1'b0;
      sleep_comparator_hysteresis_o <= 4'h0;
      osc_trim_o <= 5'h0;
      osc_band_select_o <= 3'h0;
      converter_control_o <= 16'h0;
      main_monitor_en_o <= 1'b0;
      alt_monitor_en_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rmux : 32'h0;
      irq_o <= |(irq_stat_q & irq_mask_q);
      wakeup_o <= wake_hit;
      lownoise_fb_atten_o <= ln_atten_q;
      lowpower_reference_sel_o <= lp_volt_q[POS_LP_REF +: 8];
      lowpower_fb_atten_o <= lp_volt_q[POS_LP_ATTEN];
      lowpower_blanking_o <= lp_ctrl_q[POS_BLANK +: 2];
      bias_duty_cycle_enable_o <= lp_ctrl_q[POS_DUTY];
      sleep_comparator_hysteresis_o <= lp_ctrl_q[POS_HYST +: 4];
      osc_trim_o <= ln_freq_q[POS_TRIM +: 5];
      osc_band_select_o <= ln_freq_q[POS_BAND +: 3];
      converter_control_o <= conv_q[15:0];
      main_monitor_en_o <= chan_en[0];
      alt_monitor_en_o <= chan_en[1];
    end
  end
endmodule // dcdc_supply_voltage_monitor_config_regs

/* tb/dcdc_supply_voltage_monitor_config_regs_monitor.sv */
// Purpose: port-level checks for the converter and monitor register bank
// Assumes: one clock, resets active low
// Notes: bound into every instance of the bank
`timescale 1ns/1ps
module dcdc_supply_voltage_monitor_config_regs_monitor #(
  parameter int XFER_LEN = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [dcdc_supply_voltage_monitor_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dcdc_supply_voltage_monitor_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic hibernate_state_i,
  input wire logic [dcdc_supply_voltage_monitor_pkg::DATA_W-1:0] rdata_o,
  input wire logic wakeup_o,
  input wire logic lownoise_fb_atten_o,
  input wire logic [7:0] lowpower_reference_sel_o,
  input wire logic lowpower_fb_atten_o,
  input wire logic bias_duty_cycle_enable_o,
  input wire logic [3:0] sleep_comparator_hysteresis_o,
  input wire logic [4:0] osc_trim_o,
  input wire logic [2:0] osc_band_select_o,
  input wire logic [15:0] converter_control_o,
  input wire logic main_monitor_en_o
);
  import dcdc_supply_voltage_monitor_pkg::*;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle_zero: assert property ($past(rd_i) == 1'b0 |-> rdata_o == '0)
    else $error("read data not zero outside a read");
  a_wake_in_hib: assert property (wakeup_o |-> $past(hibernate_state_i))
    else $error("wakeup outside hibernate");
  a_wake_one_cycle: assert property (wakeup_o |=> !wakeup_o)
    else $error("wakeup longer than one cycle");
  a_band_follows: assert property (wr_i && addr_i == OFS_LN_FREQ |=> ##1
    osc_band_select_o == $past(wdata_i[2:0], 2)) else $error("band output wrong");
  a_lpvolt_follows: assert property (wr_i && addr_i == OFS_LP_VOLT |=> ##1
    lowpower_reference_sel_o == $past(wdata_i[8:1], 2)
    && lowpower_fb_atten_o == $past(wdata_i[0], 2)) else $error("low-power volt output wrong");
  a_lpctrl_follows: assert property (wr_i && addr_i == OFS_LP_CTRL |=> ##1
    sleep_comparator_hysteresis_o == $past(wdata_i[15:12], 2)
    && bias_duty_cycle_enable_o == $past(wdata_i[24], 2)) else $error("lp ctrl output wrong");
  a_main_en_follows: assert property (wr_i && addr_i == OFS_MON_MAIN |=> ##1
    main_monitor_en_o == $past(wdata_i[0], 2)) else $error("monitor enable wrong");
  a_atten_from_ctrl: assert property (lownoise_fb_atten_o == converter_control_o[1])
    else $error("low-noise attenuation wrong");
  a_reset_values: assert property ($past(rst_n_i) == 1'b0 |=>
    bias_duty_cycle_enable_o && osc_trim_o == 5'h10 && lowpower_reference_sel_o == 8'hb4)
    else $error("converter reset values wrong");
endmodule // dcdc_supply_voltage_monitor_config_regs_monitor
bind dcdc_supply_voltage_monitor_config_regs dcdc_supply_voltage_monitor_config_regs_monitor #(.XFER_LEN(XFER_LEN)) u_monitor (
  .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .hibernate_state_i, .rdata_o, .wakeup_o,
  .lownoise_fb_atten_o, .lowpower_reference_sel_o, .lowpower_fb_atten_o,
  .bias_duty_cycle_enable_o, .sleep_comparator_hysteresis_o, .osc_trim_o, .osc_band_select_o,
  .converter_control_o, .main_monitor_en_o);

/* tb/testbench.sv */
// Purpose: self-checking bench for the converter and monitor register bank
// Assumes: 200 MHz clock, both resets held 20 cycles at start
// Notes: stimulus at rising edges by non-blocking assignment
`timescale 1ns/1ps
module testbench;
  import dcdc_supply_voltage_monitor_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ext_rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic hibernate_state_i = 1'b0, main_supply_above_i = 1'b0, alt_supply_above_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [DATA_W-1:0] rdata_o;
  logic irq_o, wakeup_o, lownoise_fb_atten_o, lowpower_fb_atten_o, bias_duty_cycle_enable_o;
  logic main_monitor_en_o, alt_monitor_en_o;
  logic [7:0] lowpower_reference_sel_o;
  logic [1:0] lowpower_blanking_o;
  logic [3:0] sleep_comparator_hysteresis_o;
  logic [4:0] osc_trim_o;
  logic [2:0] osc_band_select_o;
  logic [15:0] converter_control_o;
  logic [7:0] ofs [7] = '{8'h64, 8'h6c, 8'h70, 8'h78, 8'h90, 8'h94, 8'h80};
  logic [31:0] rstv [7] = '{32'h168, 32'h0300_0000, 32'h1000_0000, 0, 0, 0, 0};
  logic [31:0] msk [7] = '{32'h1ff, 32'h0300_f000, 32'h1000_0007, 0, 32'hff_ff0d, 32'hff0d, 0};
  // blanking and trim fields are written with their reset values
  logic [31:0] wrv [7] = '{32'hffff_ffff, 32'hfbff_ffff, 32'hf0ff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
  int fails = 0, checked = 0, wakes = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (wakeup_o === 1'b1) wakes++;
  dcdc_supply_voltage_monitor_config_regs #(.XFER_LEN(XFER_CYCLES)) u_dut (.clk_i, .rst_n_i, .ext_rst_n_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .hibernate_state_i, .main_supply_above_i,
    .alt_supply_above_i, .rdata_o, .irq_o, .wakeup_o, .lownoise_fb_atten_o,
    .lowpower_reference_sel_o, .lowpower_fb_atten_o, .lowpower_blanking_o,
    .bias_duty_cycle_enable_o, .sleep_comparator_hysteresis_o, .osc_trim_o,
    .osc_band_select_o, .converter_control_o, .main_monitor_en_o, .alt_monitor_en_o);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, exp);
  endtask
  task automatic supply(input logic lvl);
    @(posedge clk_i);
    main_supply_above_i <= lvl;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 12 && irq_o !== lvl; i++) @(negedge clk_i);
    chk(32'(irq_o), 32'(lvl));
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #100_000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ext_rst_n_i <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], rstv[i]);
    foreach (ofs[i]) begin
      wr(ofs[i], wrv[i]);
      rd(ofs[i], msk[i]);
    end
    chk(32'(lowpower_blanking_o), 32'h1);
    chk(32'(osc_trim_o), 32'h10);
    chk(32'(sleep_comparator_hysteresis_o), 32'hf);
    chk(32'(alt_monitor_en_o), 32'h1);
    for (int b = 0; b < 8; b++) begin
      wr(OFS_LN_FREQ, 32'h1000_0000 | 32'(b));
      rd(OFS_LN_FREQ, 32'h1000_0000 | 32'(b));
    end
    wr(OFS_CONV_CTRL, 32'h2);
    rd(OFS_SYNC_STAT, 32'h1);
    wr(OFS_CONV_CTRL, 32'h0);
    @(negedge clk_i);
    chk(32'(lownoise_fb_atten_o), 32'h1);
    chk(32'(converter_control_o), 32'h2);
    rd(OFS_CONV_CTRL, 32'h2);
    repeat (XFER_CYCLES + 2) @(posedge clk_i);
    rd(OFS_SYNC_STAT, 32'h0);
    wr(OFS_CONV_CTRL, 32'h0);
    repeat (2) @(negedge clk_i);
    chk(32'(lownoise_fb_atten_o), 32'h0);
    wr(OFS_MON_MAIN, 32'h5);
    wr(OFS_IRQ_MASK, 32'h1);
    rd(OFS_IRQ_STAT, 32'h0);
    @(posedge clk_i);
    hibernate_state_i <= 1'b1;
    supply(1'b1);
    wait_irq(1'b1);
    chk(wakes, 1);
    wr(OFS_IRQ_MASK, 32'h0);
    wait_irq(1'b0);
    wr(OFS_MON_MAIN, 32'h9);
    supply(1'b0);
    chk(wakes, 2);
    supply(1'b1);
    chk(wakes, 2);
    wr(OFS_IRQ_MASK, 32'h1);
    wait_irq(1'b1);
    rd(OFS_IRQ_STAT, 32'h3);
    wait_irq(1'b0);
    wr(OFS_MON_MAIN, 32'h00a5_c30d);
    wr(OFS_LN_FREQ, 32'h1000_0005);
    @(posedge clk_i);
    ext_rst_n_i <= 1'b0;
    @(posedge clk_i);
    ext_rst_n_i <= 1'b1;
    rd(OFS_MON_MAIN, 32'h0);
    rd(OFS_LN_FREQ, 32'h1000_0005);
    wr(OFS_MON_MAIN, 32'h00a5_c30d);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_LN_FREQ, 32'h1000_0000);
    rd(OFS_MON_MAIN, 32'h00a5_c30d);
    tally_and_finish();
  end
endmodule // testbench
